// ==== tb/acs_chk_assertions.sv ====
`timescale 1ns/10ps
module acs_chk #(
    parameter int DETECT_CYCLES = 4
) (
    input wire logic clk_sys, // clock
    input wire logic rst_n, // reset
    input wire logic clock_input_positive, // pin
    input wire logic clock_input_negative, // pin
    input wire logic [1:0] filter_cutoff_select, // code
    input wire logic [15:0] gp_reg70, // register 70
    input wire acs_pkg::acs_cutoff_e filter_cutoff, // cutoff
    input wire logic clamp_enable, // clamp
    input wire logic clk_buffer_enable, // buffer
    input wire logic single_ended_mode, // mode
    input wire logic sample_even, // strobe
    input wire logic sample_odd, // strobe
    input wire acs_pkg::acs_link_s link_out // link
);
    int lo_cnt;
    int next_lo_cnt;
    logic par;
    logic next_par;
    always_comb
    begin
        next_lo_cnt = clock_input_negative ? 0 : lo_cnt + 1;
        next_par = sample_even | (par & ~sample_odd);
    end
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lo_cnt <= 0;
            par <= 1'h0;
        end
        else
        begin
            lo_cnt <= next_lo_cnt;
            par <= next_par;
        end
    end
    default clocking dc @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    a_cutoff_set: assert property (
        filter_cutoff_select != 2'h3 |=>
        filter_cutoff == $past(filter_cutoff_select))
        else $error("cutoff not applied");
    a_cutoff_keep: assert property (
        filter_cutoff_select == 2'h3 |=> $stable(filter_cutoff))
        else $error("cutoff changed on code 3");
    a_clamp_bit: assert property (
        1'h1 |=> clamp_enable == !$past(gp_reg70[14]))
        else $error("clamp wrong");
    a_clk_mode: assert property (
        single_ended_mode != clk_buffer_enable)
        else $error("buffer and mode disagree");
    a_se_clear: assert property (
        clock_input_negative |-> ##[1:4] !single_ended_mode)
        else $error("single mode not cleared");
    a_se_set: assert property (
        lo_cnt > DETECT_CYCLES + 5 |-> single_ended_mode)
        else $error("single mode not set");
    a_even_odd_alt: assert property (
        (sample_even || sample_odd) |-> sample_odd == par)
        else $error("strobes not alternating");
    a_rise_sample: assert property (
        $rose(clock_input_positive) |-> ##[1:5] (sample_even || sample_odd))
        else $error("rise not sampled");
    a_frame_bits: assert property (
        $changed(link_out.frame) |-> $changed(link_out.bit_clk) [*8])
        else $error("frame edge without bit clock run");
    c_even: cover property (sample_even);
    c_odd: cover property (sample_odd);
    c_single: cover property ($rose(single_ended_mode));
endmodule

// ==== tb/acs_rx_model.sv ====
`timescale 1ns/10ps
module acs_rx (
    input wire logic clk_sys, // clock
    input wire logic rst_n, // reset
    input wire acs_pkg::acs_link_s link_out, // link
    output acs_pkg::acs_words_s rx_word, // word
    output logic rx_frame, // frame at first bit
    output logic rx_valid // word done
);
    logic bclk_q;
    logic [3:0] cnt;
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bclk_q <= 1'h0;
            cnt <= 4'h0;
            rx_valid <= 1'h0;
            rx_frame <= 1'h0;
            rx_word <= '0;
        end
        else
        begin
            bclk_q <= link_out.bit_clk;
            rx_valid <= 1'h0;
            // each bit clock edge carries one bit
            if (link_out.bit_clk != bclk_q)
            begin
                for (int i = 0; i < 8; i++)
                    rx_word.word[i] <= {rx_word.word[i][10:0],
                        link_out.lane[i]};
                if (cnt == 4'h0)
                    rx_frame <= link_out.frame;
                cnt <= (cnt == 4'hB) ? 4'h0 : cnt + 4'h1;
                rx_valid <= cnt == 4'hB;
            end
        end
    end
endmodule

// ==== tb/tb.sv ====
`timescale 1ns/10ps
module tb;
    logic clk_sys = 1'h0;
    logic rst_n = 1'h0;
    logic clock_input_positive = 1'h0;
    logic clock_input_negative = 1'h1;
    logic [1:0] filter_cutoff_select = 2'h0;
    logic [15:0] gp_reg70 = 16'h0;
    acs_pkg::acs_words_s adc_result = '0;
    acs_pkg::acs_cutoff_e filter_cutoff;
    logic clamp_enable, clk_buffer_enable, single_ended_mode;
    logic sample_even, sample_odd, rx_frame, rx_valid;
    acs_pkg::acs_link_s link_out;
    acs_pkg::acs_words_s rx_word;
    logic [96:0] exp_q[$];
    logic [96:0] rx_got;
    logic [31:0] lfsr = 32'hF6817037;
    int fail_count = 0;
    int n_tests = 0;
    int rises = 0;
    int n_even = 0;
    int n_odd = 0;
    acs_adc_serial #(
        .DETECT_CYCLES(4)
    ) dut (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .clock_input_positive(clock_input_positive),
        .clock_input_negative(clock_input_negative),
        .filter_cutoff_select(filter_cutoff_select),
        .gp_reg70(gp_reg70),
        .adc_result(adc_result),
        .filter_cutoff(filter_cutoff),
        .clamp_enable(clamp_enable),
        .clk_buffer_enable(clk_buffer_enable),
        .single_ended_mode(single_ended_mode),
        .sample_even(sample_even),
        .sample_odd(sample_odd),
        .link_out(link_out)
    );
    acs_rx u_rx (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .link_out(link_out),
        .rx_word(rx_word),
        .rx_frame(rx_frame),
        .rx_valid(rx_valid)
    );
    assign rx_got = {rx_frame, rx_word};
    initial
        forever #10 clk_sys = ~clk_sys;
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction
    task automatic chk(input logic [96:0] seen, exp, input string what);
        n_tests++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[ERR] %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic pulse(input int gap);
        for (int i = 0; i < 8; i++)
            adc_result.word[i] = 12'(rnd());
        if (gap > 0)
            exp_q.push_back({rises[0] == 1'h0, adc_result});
        rises++;
        clock_input_positive = 1'h1;
        #80;
        clock_input_positive = 1'h0;
        #(80 + gap);
    endtask
    always @(negedge clk_sys)
        if (rx_valid === 1'h1 && exp_q.size() > 0)
            chk(rx_got, exp_q.pop_front(), "word");
    // strobes counted mid-cycle, away from the launching edge
    always @(negedge clk_sys)
    begin
        if (sample_even === 1'h1)
            n_even++;
        if (sample_odd === 1'h1)
            n_odd++;
    end
    initial
    begin
        #50000;
        fail_count++;
        summarize();
    end
    initial
    begin
        step(12);
        chk(clamp_enable, 1'h1, "clamp reset");
        rst_n = 1'h1;
        for (int c = 0; c < 4; c++)
        begin
            filter_cutoff_select = 2'(c);
            step(2);
            chk(filter_cutoff, (c == 3) ? 2 : c, "cutoff");
        end
        gp_reg70 = 16'(rnd()) | 16'h4000;
        step(2);
        chk(clamp_enable, 1'h0, "clamp off");
        gp_reg70 = 16'(rnd()) & 16'hBFFF;
        step(2);
        chk(clamp_enable, 1'h1, "clamp on");
        chk(clk_buffer_enable, 1'h1, "buffer on");
        clock_input_negative = 1'h0;
        step(3);
        clock_input_negative = 1'h1;
        step(6);
        chk(single_ended_mode, 1'h0, "glitch");
        clock_input_negative = 1'h0;
        step(12);
        chk({single_ended_mode, clk_buffer_enable}, 2'h2, "single");
        repeat (12) pulse(0);
        step(40);
        repeat (12) pulse(160);
        step(40);
        chk(97'(exp_q.size()), 97'h0, "words left");
        chk(97'(n_even), 97'(rises / 2), "even strobes");
        chk(97'(n_odd), 97'(rises / 2), "odd strobes");
        summarize();
    end
endmodule
bind acs_adc_serial acs_chk #(
    .DETECT_CYCLES(DETECT_CYCLES)
) u_chk (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clock_input_positive(clock_input_positive),
    .clock_input_negative(clock_input_negative),
    .filter_cutoff_select(filter_cutoff_select),
    .gp_reg70(gp_reg70),
    .filter_cutoff(filter_cutoff),
    .clamp_enable(clamp_enable),
    .clk_buffer_enable(clk_buffer_enable),
    .single_ended_mode(single_ended_mode),
    .sample_even(sample_even),
    .sample_odd(sample_odd),
    .link_out(link_out)
);

// ==== verilog/acs_adc_serial.sv ====
`timescale 1ns/10ps
`include "acs_consts.svh"

module acs_adc_serial #(
    parameter int DETECT_CYCLES = `ACS_DETECT_CYCLES
) (
    input wire logic clk_sys, // system clock, 50 MHz
    input wire logic rst_n, // async reset, active low
    input wire logic clock_input_positive, // device input clock pin
    input wire logic clock_input_negative, // negative clock pin level
    input wire logic [1:0] filter_cutoff_select, // cutoff code
    input wire logic [`ACS_GPR_BITS-1:0] gp_reg70, // register 70 contents
    input wire acs_pkg::acs_words_s adc_result, // converter results
    output acs_pkg::acs_cutoff_e filter_cutoff, // cutoff for all filters
    output logic clamp_enable, // clamp active
    output logic clk_buffer_enable, // internal clock buffer on
    output logic single_ended_mode, // single-ended clock in use
    output logic sample_even, // pulse: even channels sampled
    output logic sample_odd, // pulse: odd channels sampled
    output acs_pkg::acs_link_s link_out // lanes, frame and bit clock
);

    localparam logic [`ACS_CNT_BITS-1:0] LAST_BIT =
        `ACS_CNT_BITS'(`ACS_WORD_BITS);
    localparam logic [`ACS_DET_BITS-1:0] DET_LIMIT =
        `ACS_DET_BITS'(DETECT_CYCLES);

    logic [1:0] pins_sync;
    logic pos_s;
    logic neg_s;
    logic pos_prev;
    logic rise;

    acs_sync2 #(
        .WIDTH(2)
    ) u_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .d({clock_input_negative, clock_input_positive}),
        .q(pins_sync)
    );

    assign pos_s = pins_sync[0];
    assign neg_s = pins_sync[1];
    assign rise = pos_s & ~pos_prev;

    // control group
    acs_pkg::acs_cutoff_e next_filter_cutoff;
    logic next_clamp_enable;
    logic next_single_ended;
    logic next_clk_buffer_enable;
    logic [`ACS_DET_BITS-1:0] det_cnt;
    logic [`ACS_DET_BITS-1:0] next_det_cnt;

    always_comb
    begin
        next_filter_cutoff = filter_cutoff;
        unique case (filter_cutoff_select)
            `ACS_CUT_CODE_7M5:
                next_filter_cutoff = acs_pkg::ACS_CUT_7M5;
            `ACS_CUT_CODE_10M:
                next_filter_cutoff = acs_pkg::ACS_CUT_10M;
            `ACS_CUT_CODE_14M:
                next_filter_cutoff = acs_pkg::ACS_CUT_14M;
            default:
                next_filter_cutoff = filter_cutoff;
        endcase
        next_clamp_enable = ~gp_reg70[`ACS_CLAMP_DIS_BIT];
        next_det_cnt = det_cnt;
        next_single_ended = single_ended_mode;
        if (neg_s)
        begin
            next_det_cnt = '0;
            next_single_ended = 1'h0;
        end
        else if (det_cnt < DET_LIMIT)
        begin
            next_det_cnt = det_cnt + 1'h1;
        end
        else
        begin
            next_single_ended = 1'h1;
        end
        next_clk_buffer_enable = ~next_single_ended;
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            filter_cutoff <= acs_pkg::ACS_CUT_7M5;
            clamp_enable <= `ACS_CLAMP_RESET;
            single_ended_mode <= 1'h0;
            clk_buffer_enable <= 1'h1;
            det_cnt <= '0;
        end
        else
        begin
            filter_cutoff <= next_filter_cutoff;
            clamp_enable <= next_clamp_enable;
            single_ended_mode <= next_single_ended;
            clk_buffer_enable <= next_clk_buffer_enable;
            det_cnt <= next_det_cnt;
        end
    end

    // sampling group
    logic odd_phase;
    logic next_odd_phase;
    logic next_sample_even;
    logic next_sample_odd;
    acs_pkg::acs_words_s hold;
    acs_pkg::acs_words_s next_hold;
    logic hold_odd;
    logic next_hold_odd;
    logic pend;
    logic next_pend;
    logic load;

    always_comb
    begin
        next_odd_phase = odd_phase;
        next_sample_even = 1'h0;
        next_sample_odd = 1'h0;
        next_hold = hold;
        next_hold_odd = hold_odd;
        next_pend = pend & ~load;
        if (rise)
        begin
            next_odd_phase = ~odd_phase;
            next_sample_even = ~odd_phase;
            next_sample_odd = odd_phase;
            next_hold = adc_result;
            next_hold_odd = odd_phase;
            next_pend = 1'h1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pos_prev <= 1'h0;
            odd_phase <= 1'h0;
            sample_even <= 1'h0;
            sample_odd <= 1'h0;
            hold <= '0;
            hold_odd <= 1'h0;
            pend <= 1'h0;
        end
        else
        begin
            pos_prev <= pos_s;
            odd_phase <= next_odd_phase;
            sample_even <= next_sample_even;
            sample_odd <= next_sample_odd;
            hold <= next_hold;
            hold_odd <= next_hold_odd;
            pend <= next_pend;
        end
    end

    // serializer group
    acs_pkg::acs_ser_e state;
    acs_pkg::acs_ser_e next_state;
    logic [`ACS_CNT_BITS-1:0] bit_cnt;
    logic [`ACS_CNT_BITS-1:0] next_bit_cnt;
    logic [`ACS_NUM_ADC-1:0][`ACS_WORD_BITS-1:0] shreg;
    logic [`ACS_NUM_ADC-1:0][`ACS_WORD_BITS-1:0] next_shreg;
    logic [`ACS_NUM_ADC-1:0] next_lane;
    logic next_frame;
    logic next_bit_clk;
    logic busy_done;
    logic shift;

    assign busy_done = (state == acs_pkg::ACS_SER_IDLE) |
        (bit_cnt == LAST_BIT);
    assign load = pend & busy_done;
    assign shift = (state == acs_pkg::ACS_SER_SHIFT) & (bit_cnt != LAST_BIT);

    genvar g;
    generate
        for (g = 0; g < `ACS_NUM_ADC; g++)
        begin : g_lane
            // msb first from the held word, then from the shifter
            assign next_lane[g] = load ?
                hold.word[g][`ACS_WORD_BITS-1] :
                (shift ? shreg[g][`ACS_WORD_BITS-1] :
                link_out.lane[g]);
            assign next_shreg[g] = load ?
                {hold.word[g][`ACS_WORD_BITS-2:0], 1'h0} :
                (shift ? {shreg[g][`ACS_WORD_BITS-2:0], 1'h0} : shreg[g]);
        end
    endgenerate

    always_comb
    begin
        next_state = state;
        next_bit_cnt = bit_cnt;
        next_frame = link_out.frame;
        next_bit_clk = link_out.bit_clk;
        if (load)
        begin
            next_state = acs_pkg::ACS_SER_SHIFT;
            next_bit_cnt = `ACS_CNT_BITS'(1);
            next_frame = ~hold_odd;
            next_bit_clk = ~link_out.bit_clk;
        end
        else if (shift)
        begin
            next_bit_cnt = bit_cnt + 1'h1;
            next_bit_clk = ~link_out.bit_clk;
        end
        else if (state == acs_pkg::ACS_SER_SHIFT)
        begin
            next_state = acs_pkg::ACS_SER_IDLE;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= acs_pkg::ACS_SER_IDLE;
            bit_cnt <= '0;
            shreg <= '0;
            link_out <= '0;
        end
        else
        begin
            state <= next_state;
            bit_cnt <= next_bit_cnt;
            shreg <= next_shreg;
            link_out.lane <= next_lane;
            link_out.frame <= next_frame;
            link_out.bit_clk <= next_bit_clk;
        end
    end

endmodule

// ==== verilog/acs_consts.svh ====
`ifndef ACS_CONSTS_SVH
`define ACS_CONSTS_SVH

`define ACS_NUM_ADC 8
`define ACS_NUM_CHANNELS 16
`define ACS_WORD_BITS 12
`define ACS_CNT_BITS 4
`define ACS_BIT_RATE_MULT 12
`define ACS_BITCLK_MULT 6
`define ACS_CLAMP_REG_ADDR 70
`define ACS_CLAMP_DIS_BIT 14
`define ACS_GPR_BITS 16
`define ACS_CLAMP_RESET 1'h1
`define ACS_CUT_CODE_7M5 2'h0
`define ACS_CUT_CODE_10M 2'h1
`define ACS_CUT_CODE_14M 2'h2
`define ACS_CLK_MHZ 50
`define ACS_DETECT_NS 1000
`define ACS_DETECT_CYCLES ((`ACS_DETECT_NS * `ACS_CLK_MHZ + 999) / 1000)
`define ACS_DET_BITS 12

`endif

// ==== verilog/acs_pkg.sv ====
`include "acs_consts.svh"

package acs_pkg;

    typedef enum logic [1:0] {
        ACS_CUT_7M5,
        ACS_CUT_10M,
        ACS_CUT_14M
    } acs_cutoff_e;

    typedef enum logic {
        ACS_SER_IDLE,
        ACS_SER_SHIFT
    } acs_ser_e;

    typedef struct packed {
        logic [`ACS_NUM_ADC-1:0][`ACS_WORD_BITS-1:0] word;
    } acs_words_s;

    typedef struct packed {
        logic frame;
        logic bit_clk;
        logic [`ACS_NUM_ADC-1:0] lane;
    } acs_link_s;

endpackage

// ==== verilog/acs_sync2.sv ====
`timescale 1ns/10ps

module acs_sync2 #(
    parameter int WIDTH = 2
) (
    input wire logic clk_sys, // system clock
    input wire logic rst_n, // async reset, active low
    input wire logic [WIDTH-1:0] d, // asynchronous input
    output logic [WIDTH-1:0] q // synchronised output
);

    logic [WIDTH-1:0] stage1;

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stage1 <= '0;
            q <= '0;
        end
        else
        begin
            stage1 <= d;
            q <= stage1;
        end
    end

endmodule
